// ===== dv/tb_top.sv
// Testbench for the unknown packet forwarding control bank.
// Assumes the single-cycle register port and the pulled-up strap pin.
`timescale 1ns/1ps
module tb_top;
    logic clk_sys, rst_b, reg_wr, reg_rd, strap, reg_rvalid;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    upf_pkg::upf_ctrl_t ctrl;
    int n_mismatch = 0;
    int n_tests = 0;

    // Device under test.
    upf_ctrl_bank upf_ctrl_bank_inst (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .drive_strength_strap_pin(strap), .ctrl(ctrl));

    // Clock of 100 ns period.
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // One write strobe; the bank is updated at the second edge.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        @(negedge clk_sys);
    endtask : wr

    // One read strobe; the answer stands for one cycle after the taking edge.
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        chk("rvalid", 8'h01, {7'h00, reg_rvalid});
        chk("rdata", exp, reg_rdata);
    endtask : rd

    // Reset for 16 cycles with the strap held, then let the strap load land.
    task automatic do_reset(input logic pin);
        @(posedge clk_sys);
        rst_b <= 1'b0;
        strap <= pin;
        repeat (16) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (8) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask : do_reset

    task automatic t_reset();
        do_reset(1'b1);
        chk("drive_sel", 8'h01, {6'h00, ctrl.drive_sel});
        chk("drive_ma", 8'h08, {4'h0, ctrl.drive_ma});
        rd(8'h84, 8'h40);
        rd(8'h85, 8'h00);
        rd(8'h86, 8'h00);
        do_reset(1'b0);
        chk("drive_sel", 8'h02, {6'h00, ctrl.drive_sel});
        rd(8'h84, 8'h80);
        $display("test reset done");
    endtask : t_reset

    task automatic t_drive();
        logic [7:0] ma [4] = '{8'h04, 8'h08, 8'h0a, 8'h0e};
        for (int i = 0; i < 4; i++) begin
            wr(8'h84, {i[1:0], 6'h00});
            @(negedge clk_sys);
            chk("drive_ma", ma[i], {4'h0, ctrl.drive_ma});
            chk("drive_sel", {6'h00, i[1:0]}, {6'h00, ctrl.drive_sel});
        end
        $display("test drive done");
    endtask : t_drive

    task automatic t_classes();
        wr(8'h84, 8'h3f);
        chk("mcast", 8'h3f, {2'h0, ctrl.mcast});
        wr(8'h84, 8'h01);
        chk("mcast", 8'h01, {2'h0, ctrl.mcast});
        wr(8'h85, 8'hff);
        chk("vlan", 8'h3f, {2'h0, ctrl.vlan});
        rd(8'h85, 8'h3f);
        wr(8'h85, 8'h02);
        chk("vlan", 8'h02, {2'h0, ctrl.vlan});
        wr(8'h86, 8'hff);
        chk("self", 8'h01, {7'h00, ctrl.self_filter_en});
        chk("ipmc", 8'h3f, {2'h0, ctrl.ipmc});
        rd(8'h86, 8'h7f);
        wr(8'h86, 8'h50);
        chk("ipmc", 8'h10, {2'h0, ctrl.ipmc});
        wr(8'h86, 8'h00);
        chk("self", 8'h00, {7'h00, ctrl.self_filter_en});
        $display("test classes done");
    endtask : t_classes

    task automatic t_unmapped();
        wr(8'h87, 8'hff);
        rd(8'h87, 8'h00);
        rd(8'h85, 8'h02);
        rd(8'h84, 8'h01);
        rd(8'h86, 8'h00);
        $display("test unmapped done");
    endtask : t_unmapped

    // A write right after reset release takes priority over the strap load.
    task automatic t_sw_first();
        @(posedge clk_sys);
        rst_b <= 1'b0;
        strap <= 1'b1;
        repeat (16) @(posedge clk_sys);
        rst_b <= 1'b1;
        wr(8'h84, 8'h00);
        repeat (6) @(negedge clk_sys);
        chk("drive_sel", 8'h00, {6'h00, ctrl.drive_sel});
        chk("drive_ma", 8'h04, {4'h0, ctrl.drive_ma});
        rd(8'h84, 8'h00);
        $display("test software first done");
    endtask : t_sw_first

    task automatic report_and_stop();
        $display("Checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : report_and_stop

    // Main sequence.
    initial begin
        rst_b = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        strap = 1'b1;
        t_reset();
        t_drive();
        t_classes();
        t_unmapped();
        t_sw_first();
        report_and_stop();
    end

    // Watchdog well beyond the hundred or so cycles the tests take.
    initial begin
        #(4000 * 100);
        n_mismatch++;
        report_and_stop();
    end
endmodule : tb_top

// ===== logic/upf_ctrl_bank.sv
// Control register bank for unknown packet forwarding and drive strength.
// Assumes a single-cycle management write/read port on clk_sys.
// What this block does
// (RULE1) Drive code selects 4, 8, 10, 14 mA.
// (RULE2) Strap loads inverted high bit, same low.
// (RULE3) Multicast forward enable at first register bit5.
// (RULE4) Multicast port map, zero resets, bit0 port1.
// (RULE5) VLAN forward enable at second register bit5.
// (RULE6) VLAN port map, one bit per port.
// (RULE7) Self-address filter enable at third register bit6.
// (RULE8) IP multicast forward enable at bit5.
// (RULE9) IP multicast port map in bits 4:0.
// (RULE10) Reserved bits read zero, ignore writes.
`timescale 1ns/1ps
module upf_ctrl_bank (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst_b,
    // Management register port.
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // Strap pin with internal pull-up.
    input wire logic drive_strength_strap_pin,
    // Controls to the forwarding fabric and pad ring.
    output upf_pkg::upf_ctrl_t ctrl
);

    logic [7:0] drv_mcast_q;
    logic [7:0] vlan_q;
    logic [7:0] self_ipmc_q;
    logic [3:0] drive_ma_q;
    logic [7:0] rdata_q;
    logic rvalid_q;
    logic sw_drv_q;
    logic strap_level;
    logic strap_load;
    logic wr_drv;
    logic wr_vlan;
    logic wr_self;
    logic [7:0] rdata_d;

    upf_strap_sync u_strap (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .strap_pin(drive_strength_strap_pin),
        .strap_level(strap_level),
        .strap_load(strap_load)
    );

    // Address decode of the three writable registers.
    assign wr_drv = reg_wr && (reg_addr == upf_pkg::UPF_OFS_DRV_MCAST);
    assign wr_vlan = reg_wr && (reg_addr == upf_pkg::UPF_OFS_VLAN);
    assign wr_self = reg_wr && (reg_addr == upf_pkg::UPF_OFS_SELF_IPMC);

    // A software write of the drive field before the strap settles wins.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            sw_drv_q <= 1'b0;
        end else if (wr_drv) begin
            sw_drv_q <= 1'b1;
        end
    end

    // First register: drive select and unknown multicast forwarding.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            drv_mcast_q <= {upf_pkg::UPF_DRV_RESET, 1'b0, upf_pkg::UPF_MAP_RESET};
        end else if (wr_drv) begin
            // (RULE3) Multicast enable and map.
            drv_mcast_q <= reg_wdata & upf_pkg::UPF_MASK_DRV_MCAST;
        end else if (strap_load && !sw_drv_q) begin
            // (RULE2) Strap sets drive code.
            drv_mcast_q[upf_pkg::UPF_DRV_HI] <= ~strap_level;
            drv_mcast_q[upf_pkg::UPF_DRV_LO] <= strap_level;
        end
    end

    // Second register: unknown VLAN ID forwarding.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            vlan_q <= {3'h0, upf_pkg::UPF_MAP_RESET};
        end else if (wr_vlan) begin
            // (RULE10) Reserved bits masked off.
            vlan_q <= reg_wdata & upf_pkg::UPF_MASK_VLAN;
        end
    end

    // Third register: self-address filter and unknown IP multicast.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            self_ipmc_q <= {3'h0, upf_pkg::UPF_MAP_RESET};
        end else if (wr_self) begin
            // (RULE10) Reserved bit masked off.
            self_ipmc_q <= reg_wdata & upf_pkg::UPF_MASK_SELF_IPMC;
        end
    end

    // Drive current in milliamps, one cycle behind the select field.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            drive_ma_q <= upf_pkg::UPF_MA_CODE1;
        end else begin
            // (RULE1) Code to current map.
            unique case (drv_mcast_q[upf_pkg::UPF_DRV_HI:upf_pkg::UPF_DRV_LO])
                2'h0: drive_ma_q <= upf_pkg::UPF_MA_CODE0;
                2'h1: drive_ma_q <= upf_pkg::UPF_MA_CODE1;
                2'h2: drive_ma_q <= upf_pkg::UPF_MA_CODE2;
                2'h3: drive_ma_q <= upf_pkg::UPF_MA_CODE3;
            endcase
        end
    end

    // Read mux; unmapped offsets answer zero.
    always_comb begin
        unique case (reg_addr)
            upf_pkg::UPF_OFS_DRV_MCAST: rdata_d = drv_mcast_q;
            upf_pkg::UPF_OFS_VLAN: rdata_d = vlan_q;
            upf_pkg::UPF_OFS_SELF_IPMC: rdata_d = self_ipmc_q;
            default: rdata_d = upf_pkg::UPF_RD_UNMAPPED;
        endcase
    end

    // Read data register, valid one cycle after the read strobe.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rdata_q <= upf_pkg::UPF_RD_UNMAPPED;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= reg_rd;
            if (reg_rd) begin
                rdata_q <= rdata_d;
            end
        end
    end

    assign reg_rdata = rdata_q;
    assign reg_rvalid = rvalid_q;

    // Field outputs straight from the registers.
    assign ctrl.drive_sel = drv_mcast_q[upf_pkg::UPF_DRV_HI:upf_pkg::UPF_DRV_LO];
    assign ctrl.drive_ma = drive_ma_q;
    // (RULE4) Multicast port map out.
    assign ctrl.mcast.fwd_en = drv_mcast_q[upf_pkg::UPF_FWD_BIT];
    assign ctrl.mcast.port_map = drv_mcast_q[upf_pkg::UPF_MAP_HI:0];
    // (RULE5) VLAN enable out.
    assign ctrl.vlan.fwd_en = vlan_q[upf_pkg::UPF_FWD_BIT];
    // (RULE6) VLAN port map out.
    assign ctrl.vlan.port_map = vlan_q[upf_pkg::UPF_MAP_HI:0];
    // (RULE7) Self filter enable out.
    assign ctrl.self_filter_en = self_ipmc_q[upf_pkg::UPF_SELF_BIT];
    // (RULE8) IP multicast enable out.
    assign ctrl.ipmc.fwd_en = self_ipmc_q[upf_pkg::UPF_FWD_BIT];
    // (RULE9) IP multicast map out.
    assign ctrl.ipmc.port_map = self_ipmc_q[upf_pkg::UPF_MAP_HI:0];

    default clocking dc @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    // A software write of the first register with no strap load due.
    sequence s_wr_mcast;
        wr_drv && !strap_load;
    endsequence

    // Read strobes of the third register and of an unmapped offset.
    sequence s_rd_self;
        reg_rd && (reg_addr == upf_pkg::UPF_OFS_SELF_IPMC);
    endsequence
    sequence s_rd_unmapped;
        reg_rd && (reg_addr != upf_pkg::UPF_OFS_DRV_MCAST)
            && (reg_addr != upf_pkg::UPF_OFS_VLAN)
            && (reg_addr != upf_pkg::UPF_OFS_SELF_IPMC);
    endsequence

    // Checks next to the logic above.
    drive_map_a: assert property ( // RULE1
        (drv_mcast_q[7:6] == 2'h2) |=> (drive_ma_q == 4'ha))
        else $error("drive current does not follow code 10");
    strap_load_a: assert property ( // RULE2
        (strap_load && !sw_drv_q && !wr_drv) |=> (drv_mcast_q[7] != drv_mcast_q[6]))
        else $error("strap did not load complementary drive bits");
    mcast_en_a: assert property ( // RULE3
        s_wr_mcast |=> (ctrl.mcast.fwd_en == $past(reg_wdata[5])))
        else $error("multicast enable not written");
    mcast_map_a: assert property ( // RULE4
        s_wr_mcast |=> (ctrl.mcast.port_map == $past(reg_wdata[4:0])))
        else $error("multicast map not written");
    vlan_en_a: assert property ( // RULE5
        wr_vlan |=> (ctrl.vlan.fwd_en == $past(reg_wdata[5])))
        else $error("vlan enable not written");
    vlan_hold_a: assert property ( // RULE6
        (!wr_vlan) |=> $stable(ctrl.vlan.port_map))
        else $error("vlan map changed without a write");
    self_en_a: assert property ( // RULE7
        wr_self |=> (ctrl.self_filter_en == $past(reg_wdata[6])))
        else $error("self filter enable not written");
    ipmc_en_a: assert property ( // RULE8
        wr_self |=> (ctrl.ipmc.fwd_en == $past(reg_wdata[5])))
        else $error("ip multicast enable not written");
    ipmc_map_a: assert property ( // RULE9
        wr_self |=> (ctrl.ipmc.port_map == $past(reg_wdata[4:0])))
        else $error("ip multicast map not written");
    reserved_zero_a: assert property ( // RULE10
        (reg_rd && (reg_addr == upf_pkg::UPF_OFS_VLAN)) |=>
            (reg_rvalid && reg_rdata[7:6] == 2'h0))
        else $error("reserved bits read nonzero");

    // Every drive code maps to its current one cycle later.
    drive_all_a: assert property ( // RULE1
        1'b1 |=> (drive_ma_q == (($past(ctrl.drive_sel) == 2'h0) ? 4'h4 :
            ($past(ctrl.drive_sel) == 2'h1) ? 4'h8 :
            ($past(ctrl.drive_sel) == 2'h2) ? 4'ha : 4'he)))
        else $error("drive current does not follow the drive code");
    // The strap load gives the inverted high bit and the plain low bit.
    strap_value_a: assert property ( // RULE2
        (strap_load && !sw_drv_q && !wr_drv) |=>
            (ctrl.drive_sel == {~$past(strap_level), $past(strap_level)}))
        else $error("strap level not loaded into the drive code");
    vlan_map_a: assert property ( // RULE6
        wr_vlan |=> (ctrl.vlan.port_map == $past(reg_wdata[4:0])))
        else $error("vlan map not written");
    // Read answer follows each read strobe by exactly one cycle.
    rvalid_follow_a: assert property ( // RULE10
        1'b1 |=> (reg_rvalid == $past(reg_rd)))
        else $error("read valid does not follow the read strobe");
    self_read_a: assert property ( // RULE10
        s_rd_self |=> (reg_rdata == {1'b0, $past(self_ipmc_q[6:0])}))
        else $error("third register read back wrong");
    unmapped_read_a: assert property ( // RULE10
        s_rd_unmapped |=> (reg_rdata == 8'h00))
        else $error("unmapped offset read nonzero");
    // Reserved bits never hold a one, whatever software writes.
    reserved_hold_a: assert property ( // RULE10
        1'b1 |-> ((vlan_q[7:6] == 2'h0) && !self_ipmc_q[7]))
        else $error("reserved bit stored a one");

endmodule : upf_ctrl_bank

// ===== logic/upf_pkg.sv
// Package for the unknown packet forwarding control bank.
// Assumes an 8-bit management register port on the switch clock.
package upf_pkg;

    // Register offsets on the management port.
    localparam logic [7:0] UPF_OFS_DRV_MCAST = 8'h84;
    localparam logic [7:0] UPF_OFS_VLAN = 8'h85;
    localparam logic [7:0] UPF_OFS_SELF_IPMC = 8'h86;

    // Field positions inside the control registers.
    localparam int UPF_DRV_HI = 7;
    localparam int UPF_DRV_LO = 6;
    localparam int UPF_SELF_BIT = 6;
    localparam int UPF_FWD_BIT = 5;
    localparam int UPF_MAP_HI = 4;

    // Writable bits of each register; the rest are reserved.
    localparam logic [7:0] UPF_MASK_DRV_MCAST = 8'hff;
    localparam logic [7:0] UPF_MASK_VLAN = 8'h3f;
    localparam logic [7:0] UPF_MASK_SELF_IPMC = 8'h7f;

    // Values after reset.
    localparam logic [1:0] UPF_DRV_RESET = 2'h1;
    localparam logic [4:0] UPF_MAP_RESET = 5'h00;
    localparam logic [7:0] UPF_RD_UNMAPPED = 8'h00;

    // Drive codes and their currents in milliamps.
    localparam logic [3:0] UPF_MA_CODE0 = 4'h4;
    localparam logic [3:0] UPF_MA_CODE1 = 4'h8;
    localparam logic [3:0] UPF_MA_CODE2 = 4'ha;
    localparam logic [3:0] UPF_MA_CODE3 = 4'he;

    // Cycles after reset release before the synchronised strap is valid.
    localparam logic [1:0] UPF_STRAP_SETTLE = 2'h2;

    // One forwarding class: enable plus port map, bit 0 is port 1.
    typedef struct packed {
        logic fwd_en;
        logic [4:0] port_map;
    } upf_class_t;

    // All control outputs of the bank.
    typedef struct packed {
        logic [1:0] drive_sel;
        logic [3:0] drive_ma;
        logic self_filter_en;
        upf_class_t mcast;
        upf_class_t vlan;
        upf_class_t ipmc;
    } upf_ctrl_t;

endpackage : upf_pkg

// ===== logic/upf_strap_sync.sv
// Strap pin synchroniser with a one-shot load pulse after reset release.
// Assumes the strap pin is steady around reset and asynchronous to clk_sys.
`timescale 1ns/1ps
module upf_strap_sync (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst_b,
    // Strap pin and its captured level.
    input wire logic strap_pin,
    output logic strap_level,
    output logic strap_load
);

    logic meta_q;
    logic sync_q;
    logic [1:0] settle_q;
    logic load_q;

    // Two flip-flops bring the pin into the clock domain.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
        end else begin
            meta_q <= strap_pin;
            sync_q <= meta_q;
        end
    end

    // Count until the chain holds a real sample, then pulse once.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            settle_q <= 2'h0;
            load_q <= 1'b0;
        end else begin
            load_q <= (settle_q == upf_pkg::UPF_STRAP_SETTLE - 2'h1);
            if (settle_q != upf_pkg::UPF_STRAP_SETTLE) begin
                settle_q <= settle_q + 2'h1;
            end
        end
    end

    assign strap_level = sync_q;
    assign strap_load = load_q;

endmodule : upf_strap_sync
